// >>> cg_ctrl_map.vh
// offsets, field positions, reset values and timing counts of the control bytes
`ifndef CG_CTRL_MAP_VH
`define CG_CTRL_MAP_VH

// byte offsets on the management bus
`define CG_OFF_IDENT 8'h07
`define CG_OFF_SPREAD 8'h08
`define CG_OFF_DYNSEL 8'h09
`define CG_OFF_WDOG 8'h0a
`define CG_OFF_NLOW 8'h0b
`define CG_OFF_NHIGH_M 8'h0c

// spread and drive byte fields
`define CG_B8_CPU_DEPTH 7
`define CG_B8_CPU_SHAPE 6
`define CG_B8_SRC_ON 5
`define CG_B8_SRC_DEPTH 4
`define CG_B8_USB_DRV 2
`define CG_B8_PCI_DRV 1
`define CG_B8_WR_MASK 8'hf6
`define CG_B8_RESET 8'h06

// dynamic frequency and soft select byte fields
`define CG_B9_CEIL_HI 7
`define CG_B9_CEIL_LO 5
`define CG_B9_DF_ON 4
`define CG_B9_SEL_HI 3
`define CG_B9_RESET 8'h00

// watchdog byte fields
`define CG_B10_RECOV 7
`define CG_B10_TSEL 6
`define CG_B10_SCALE 5
`define CG_B10_ALARM 4
`define CG_B10_PER_HI 3
`define CG_B10_PER_LO 1
`define CG_B10_ENABLE 0
`define CG_B10_SCALE_RST 1'b1

// divider byte fields
`define CG_B12_N8 7

// watchdog time units counted in 20 MHz clocks, reset pulse in clocks
`define CG_WD_SHORT_CYC 26'h059b8c0
`define CG_WD_LONG_CYC 26'h2ca1c80
`define CG_RST_PULSE_CYC 8'h40

// device address and identity (arbitrary values)
`define CG_DEV_ADDR 7'h2a
`define CG_REV_CODE 4'h3
`define CG_VEN_CODE 4'h5

`endif

// >>> cg_watchdog.v
// watchdog timer: period count, timeout event, reset pulse and reload request
`timescale 1ns/100ps
module cg_watchdog #(
  parameter CW = 26,
  parameter [CW-1:0] SHORT_CYC = 26'd5880000,
  parameter [CW-1:0] LONG_CYC = 26'd46800000,
  parameter [7:0] PULSE_CYC = 8'd64
)(
  input wire core_clk, // system clock
  input wire rstn, // async reset, active low
  input wire start, // pulse: load period and run
  input wire run, // level: watchdog enabled
  input wire [2:0] period_code, // units to count, 000 is test mode
  input wire long_scale, // 1 selects long time unit
  input wire reset_only, // 1: reset only, 0: reset and reload
  output wire expire, // pulse: period counted out
  output wire system_reset_out_n, // reset to system, active low
  output reg recovery_reload // pulse: reload recovery frequency
);

reg active_reg;
reg [2:0] units_reg;
reg [CW-1:0] tick_reg;
reg [7:0] pulse_reg;
reg expire_reg;
wire test_mode;
wire [CW-1:0] unit_len;

assign test_mode = (period_code == 3'b000);
// test mode counts a single clock as its unit
assign unit_len = test_mode ? {{(CW-1){1'b0}}, 1'b1} :
  (long_scale ? LONG_CYC : SHORT_CYC);
assign expire = expire_reg;
assign system_reset_out_n = (pulse_reg == 8'h00);

// unit ticks and remaining units
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    active_reg <= 1'b0;
    units_reg <= 3'h0;
    tick_reg <= {CW{1'b0}};
    expire_reg <= 1'b0;
  end
  else
  begin
    expire_reg <= 1'b0;
    if (start)
    begin
      active_reg <= 1'b1;
      units_reg <= test_mode ? 3'h1 : period_code;
      tick_reg <= unit_len - {{(CW-1){1'b0}}, 1'b1};
    end
    else if (!run)
      active_reg <= 1'b0;
    else if (active_reg)
    begin
      if (tick_reg != {CW{1'b0}})
        tick_reg <= tick_reg - {{(CW-1){1'b0}}, 1'b1};
      else if (units_reg <= 3'h1)
      begin
        active_reg <= 1'b0;
        expire_reg <= 1'b1;
      end
      else
      begin
        units_reg <= units_reg - 3'h1;
        tick_reg <= unit_len - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
end

// reset pulse and reload request on timeout
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    pulse_reg <= 8'h00;
    recovery_reload <= 1'b0;
  end
  else
  begin
    recovery_reload <= expire_reg & ~reset_only;
    if (expire_reg)
      pulse_reg <= PULSE_CYC;
    else if (pulse_reg != 8'h00)
      pulse_reg <= pulse_reg - 8'h01;
  end
end

endmodule

// >>> cg_ctrl_bytes.v
// control bytes 7 to 12 with two-wire slave and watchdog
`timescale 1ns/100ps
`include "cg_ctrl_map.vh"
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - byte 8 bits 7,6 set cpu spread
// - byte 8 bit 5 switches src spread
// - byte 8 bit 4 sets src depth
// - bits 2,1 drive strength, reset 1x
// - byte 9 ceiling and dynamic enable
// - byte 9 low nibble soft select
// - byte 10 bit 7 recovery source
// - timeout resets, optionally reloads recovery
// - bit 5 time unit, reset long
// - timeout sets alarm flag
// - clearing period field clears alarm
// - period code counts n units, 000 is test mode
// - writing enable loads and starts
// - n and m drive cpu synthesizer
// - ratio from pins or soft select
// - bypass bit picks soft select
// - programmable enable gates synthesizer use
//////////////////////////////////////////////////////////////////////////////
module cg_ctrl_bytes #(
  parameter [25:0] WD_SHORT_CYC = `CG_WD_SHORT_CYC,
  parameter [25:0] WD_LONG_CYC = `CG_WD_LONG_CYC,
  parameter [6:0] DEV_ADDR = `CG_DEV_ADDR,
  parameter [3:0] REV_CODE = `CG_REV_CODE,
  parameter [3:0] VEN_CODE = `CG_VEN_CODE
)(
  input wire core_clk, // system clock, 20 MHz
  input wire rstn, // async reset, active low
  input wire scl_in, // bus clock level
  input wire sda_in, // bus data level
  output wire sda_out, // bus data drive value
  output wire sda_oe, // high while pulling data low
  input wire [4:0] latched_freq_pins, // frequency pins caught at power-up
  input wire pin_select_bypass, // 1 selects soft frequency select
  input wire prog_cpu_on, // programmable cpu frequency enable
  output wire cpu_pll_spread_depth, // 0 half percent, 1 one percent
  output wire cpu_pll_spread_shape, // 0 down, 1 center
  output wire serial_ref_spread_on, // src spread enable
  output wire serial_ref_spread_depth, // src spread depth
  output wire usb_drive_1x, // 48 MHz drive, 0 is 2x
  output wire pci_drive_1x, // 33 MHz drive, 0 is 2x
  output wire [2:0] dyn_freq_ceiling, // dynamic frequency ceiling
  output wire dyn_freq_on, // dynamic frequency enable
  output wire [3:0] soft_freq_select, // software frequency select
  output wire recovery_use_stored, // 1 restores stored recovery value
  output reg [4:0] freq_ratio_select, // ratio source in force
  output reg cpu_synth_in_use, // synthesizer values in force
  output reg [8:0] cpu_synth_multiplier, // n value
  output reg [6:0] cpu_synth_divider, // m value
  output wire timeout_flag, // watchdog alarm
  output wire system_reset_out_n, // system reset, active low
  output wire recovery_reload // pulse: reload recovery frequency
);

//////////////////////////////////////////////////////////////////////////////
// serial slave states
localparam [5:0] ST_IDLE = 6'b000001;
localparam [5:0] ST_DEV = 6'b000010;
localparam [5:0] ST_CMD = 6'b000100;
localparam [5:0] ST_WDATA = 6'b001000;
localparam [5:0] ST_RDATA = 6'b010000;
localparam [5:0] ST_SKIP = 6'b100000;

reg [5:0] state_reg;
reg [5:0] after_ack_reg;
reg [3:0] bit_reg;
reg [7:0] shift_reg;
reg [7:0] ptr_reg;
reg sda_low_reg;
reg scl_last_reg;
reg sda_last_reg;
reg wr_pulse_reg;
reg [7:0] wr_addr_reg;
reg [7:0] wr_data_reg;

// control byte storage
reg [7:0] spread_reg;
reg [7:0] dynsel_reg;
reg recov_reg;
reg tsel_reg;
reg scale_reg;
reg alarm_reg;
reg [2:0] period_reg;
reg wd_on_reg;
reg wd_start_reg;
reg [8:0] n_reg;
reg [6:0] m_reg;
reg [7:0] rd_data;

wire scl_rise;
wire scl_fall;
wire bus_start;
wire bus_stop;
wire wd_expire;
wire wr_wdog;

//////////////////////////////////////////////////////////////////////////////
// bus line edges and conditions
assign scl_rise = scl_in & ~scl_last_reg;
assign scl_fall = ~scl_in & scl_last_reg;
assign bus_start = scl_in & scl_last_reg & sda_last_reg & ~sda_in;
assign bus_stop = scl_in & scl_last_reg & ~sda_last_reg & sda_in;
// open drain: only ever pulls low
assign sda_out = 1'b0;
assign sda_oe = sda_low_reg;

// previous line levels
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    scl_last_reg <= 1'b1;
    sda_last_reg <= 1'b1;
  end
  else
  begin
    scl_last_reg <= scl_in;
    sda_last_reg <= sda_in;
  end
end

//////////////////////////////////////////////////////////////////////////////
// read multiplexer
always @*
begin
  case (ptr_reg)
    `CG_OFF_IDENT: rd_data = {REV_CODE, VEN_CODE};
    `CG_OFF_SPREAD: rd_data = spread_reg;
    `CG_OFF_DYNSEL: rd_data = dynsel_reg;
    `CG_OFF_WDOG: rd_data = {recov_reg, tsel_reg, scale_reg, alarm_reg,
      period_reg, wd_on_reg};
    `CG_OFF_NLOW: rd_data = n_reg[7:0];
    `CG_OFF_NHIGH_M: rd_data = {n_reg[8], m_reg};
    default: rd_data = 8'h00;
  endcase
end

//////////////////////////////////////////////////////////////////////////////
// byte-level slave: address, command, then data bytes with auto increment
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    state_reg <= ST_IDLE;
    after_ack_reg <= ST_IDLE;
    bit_reg <= 4'h0;
    shift_reg <= 8'h00;
    ptr_reg <= 8'h00;
    sda_low_reg <= 1'b0;
    wr_pulse_reg <= 1'b0;
    wr_addr_reg <= 8'h00;
    wr_data_reg <= 8'h00;
  end
  else
  begin
    wr_pulse_reg <= 1'b0;
    if (bus_stop)
    begin
      state_reg <= ST_IDLE;
      sda_low_reg <= 1'b0;
    end
    else if (bus_start)
    begin
      state_reg <= ST_DEV;
      bit_reg <= 4'h0;
      sda_low_reg <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (bit_reg < 4'h8)
      begin
        // a read byte shifts out on the falls only
        if (state_reg != ST_RDATA)
          shift_reg <= {shift_reg[6:0], sda_in};
        bit_reg <= bit_reg + 4'h1;
      end
      // host acknowledge of a read byte
      else if (state_reg == ST_RDATA && bit_reg == 4'h9)
      begin
        if (sda_in)
          state_reg <= ST_SKIP;
        else
          ptr_reg <= ptr_reg + 8'h01;
      end
    end
    else if (scl_fall)
    begin
      case (state_reg)
        ST_DEV:
        begin
          if (bit_reg == 4'h8)
          begin
            bit_reg <= 4'h9;
            if (shift_reg[7:1] == DEV_ADDR)
            begin
              sda_low_reg <= 1'b1;
              after_ack_reg <= shift_reg[0] ? ST_RDATA : ST_CMD;
            end
            else
              state_reg <= ST_SKIP;
          end
          else if (bit_reg == 4'h9)
          begin
            bit_reg <= 4'h0;
            state_reg <= after_ack_reg;
            sda_low_reg <= 1'b0;
            if (after_ack_reg == ST_RDATA)
            begin
              shift_reg <= {rd_data[6:0], 1'b0};
              sda_low_reg <= ~rd_data[7];
              bit_reg <= 4'h0;
            end
          end
        end
        ST_CMD, ST_WDATA:
        begin
          if (bit_reg == 4'h8)
          begin
            bit_reg <= 4'h9;
            sda_low_reg <= 1'b1;
            if (state_reg == ST_CMD)
              ptr_reg <= shift_reg;
            else
            begin
              wr_pulse_reg <= 1'b1;
              wr_addr_reg <= ptr_reg;
              wr_data_reg <= shift_reg;
              ptr_reg <= ptr_reg + 8'h01;
            end
          end
          else if (bit_reg == 4'h9)
          begin
            bit_reg <= 4'h0;
            sda_low_reg <= 1'b0;
            state_reg <= ST_WDATA;
          end
        end
        ST_RDATA:
        begin
          if (bit_reg < 4'h8)
          begin
            sda_low_reg <= ~shift_reg[7];
            shift_reg <= {shift_reg[6:0], 1'b0};
          end
          else if (bit_reg == 4'h8)
          begin
            sda_low_reg <= 1'b0;
            bit_reg <= 4'h9;
          end
          else
          begin
            bit_reg <= 4'h0;
            shift_reg <= {rd_data[6:0], 1'b0};
            sda_low_reg <= ~rd_data[7];
          end
        end
        default:
          sda_low_reg <= 1'b0;
      endcase
    end
  end
end

//////////////////////////////////////////////////////////////////////////////
// register writes
assign wr_wdog = wr_pulse_reg && (wr_addr_reg == `CG_OFF_WDOG);

always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    spread_reg <= `CG_B8_RESET;
    dynsel_reg <= `CG_B9_RESET;
    recov_reg <= 1'b0;
    tsel_reg <= 1'b0;
    scale_reg <= `CG_B10_SCALE_RST;
    period_reg <= 3'h0;
    wd_on_reg <= 1'b0;
    wd_start_reg <= 1'b0;
    n_reg <= 9'h000;
    m_reg <= 7'h00;
  end
  else
  begin
    wd_start_reg <= 1'b0;
    if (wr_pulse_reg)
    begin
      case (wr_addr_reg)
        // spread fields, reserved bits stay zero
        `CG_OFF_SPREAD: spread_reg <= wr_data_reg & `CG_B8_WR_MASK;
        `CG_OFF_DYNSEL: dynsel_reg <= wr_data_reg;
        `CG_OFF_WDOG:
        begin
          recov_reg <= wr_data_reg[`CG_B10_RECOV];
          tsel_reg <= wr_data_reg[`CG_B10_TSEL];
          scale_reg <= wr_data_reg[`CG_B10_SCALE];
          period_reg <= wr_data_reg[`CG_B10_PER_HI:`CG_B10_PER_LO];
          wd_on_reg <= wr_data_reg[`CG_B10_ENABLE];
          // a written one starts the count
          wd_start_reg <= wr_data_reg[`CG_B10_ENABLE];
        end
        `CG_OFF_NLOW: n_reg[7:0] <= wr_data_reg;
        `CG_OFF_NHIGH_M:
        begin
          n_reg[8] <= wr_data_reg[`CG_B12_N8];
          m_reg <= wr_data_reg[6:0];
        end
        default: ;
      endcase
    end
  end
end

//////////////////////////////////////////////////////////////////////////////
// alarm flag: a timeout in the clearing cycle wins
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
    alarm_reg <= 1'b0;
  else if (wd_expire)
    alarm_reg <= 1'b1;
  else if (wr_wdog &&
    wr_data_reg[`CG_B10_PER_HI:`CG_B10_PER_LO] == 3'h0)
    alarm_reg <= 1'b0;
end

//////////////////////////////////////////////////////////////////////////////
// control outputs
// cpu spread depth and shape
assign cpu_pll_spread_depth = spread_reg[`CG_B8_CPU_DEPTH];
assign cpu_pll_spread_shape = spread_reg[`CG_B8_CPU_SHAPE];
assign serial_ref_spread_on = spread_reg[`CG_B8_SRC_ON];
assign serial_ref_spread_depth = spread_reg[`CG_B8_SRC_DEPTH];
assign usb_drive_1x = spread_reg[`CG_B8_USB_DRV];
assign pci_drive_1x = spread_reg[`CG_B8_PCI_DRV];
assign dyn_freq_ceiling = dynsel_reg[`CG_B9_CEIL_HI:`CG_B9_CEIL_LO];
assign dyn_freq_on = dynsel_reg[`CG_B9_DF_ON];
assign soft_freq_select = dynsel_reg[`CG_B9_SEL_HI:0];
assign recovery_use_stored = recov_reg;
assign timeout_flag = alarm_reg;

// frequency source selection
always @(posedge core_clk or negedge rstn)
begin
  if (!rstn)
  begin
    freq_ratio_select <= 5'h00;
    cpu_synth_in_use <= 1'b0;
    cpu_synth_multiplier <= 9'h000;
    cpu_synth_divider <= 7'h00;
  end
  else
  begin
    // ratio from pins or soft select
    freq_ratio_select <= pin_select_bypass ?
      {1'b0, dynsel_reg[`CG_B9_SEL_HI:0]} : latched_freq_pins;
    cpu_synth_in_use <= prog_cpu_on;
    // n and m in force when enabled
    cpu_synth_multiplier <= prog_cpu_on ? n_reg : 9'h000;
    cpu_synth_divider <= prog_cpu_on ? m_reg : 7'h00;
  end
end

//////////////////////////////////////////////////////////////////////////////
// watchdog timer
// scale bit picks the time unit
// timer select picks the timeout action
cg_watchdog #(
  .CW(26),
  .SHORT_CYC(WD_SHORT_CYC),
  .LONG_CYC(WD_LONG_CYC),
  .PULSE_CYC(`CG_RST_PULSE_CYC)
) u_wdog (
  .core_clk(core_clk),
  .rstn(rstn),
  .start(wd_start_reg),
  .run(wd_on_reg),
  .period_code(period_reg),
  .long_scale(scale_reg),
  .reset_only(tsel_reg),
  .expire(wd_expire),
  .system_reset_out_n(system_reset_out_n),
  .recovery_reload(recovery_reload)
);

endmodule

// >>> cg_ctrl_bytes_checker.sv
// concurrent checks on the control byte ports
`timescale 1ns/100ps
module cg_ctrl_bytes_checker (
  input wire core_clk, // system clock
  input wire rstn, // async reset, active low
  input wire sda_oe, // device pulls data low
  input wire [4:0] latched_freq_pins, // pins at power-up
  input wire pin_select_bypass, // soft select chosen
  input wire prog_cpu_on, // synthesizer enable
  input wire [3:0] soft_freq_select, // soft select bits
  input wire [4:0] freq_ratio_select, // ratio in force
  input wire cpu_synth_in_use, // synthesizer in force
  input wire [8:0] cpu_synth_multiplier, // n value
  input wire [6:0] cpu_synth_divider, // m value
  input wire timeout_flag, // watchdog alarm
  input wire system_reset_out_n, // system reset
  input wire recovery_reload // reload pulse
);
  reg [6:0] lo_cnt;
  reg [4:0] ratio_exp;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////////
  // reset pulse length so far, and the ratio source now due
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lo_cnt <= 7'h00;
      ratio_exp <= 5'h00;
    end
    else
    begin
      lo_cnt <= system_reset_out_n ? 7'h00 : lo_cnt + 7'h01;
      ratio_exp <= pin_select_bypass ? {1'b0, soft_freq_select} :
        latched_freq_pins;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_pulse_len;
    $rose(system_reset_out_n) |-> lo_cnt == 7'h40;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("system reset pulse length wrong");
  property p_flag_reset;
    $rose(timeout_flag) |-> ##[0:2] !system_reset_out_n;
  endproperty
  a_flag_reset: assert property (p_flag_reset)
    else $error("timeout without system reset");
  property p_reload_once;
    recovery_reload |=> !recovery_reload;
  endproperty
  a_reload_once: assert property (p_reload_once)
    else $error("reload pulse too long");
  property p_reload_cause;
    recovery_reload |-> timeout_flag && !system_reset_out_n ##0 1'b1;
  endproperty
  a_reload_cause: assert property (p_reload_cause)
    else $error("reload without timeout");
  property p_ratio;
    freq_ratio_select == ratio_exp;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("ratio source wrong");
  property p_synth;
    $past(rstn) |-> cpu_synth_in_use == $past(prog_cpu_on);
  endproperty
  a_synth: assert property (p_synth)
    else $error("synthesizer use wrong");
  property p_synth_zero;
    !cpu_synth_in_use |-> cpu_synth_multiplier == 9'h000 &&
      cpu_synth_divider == 7'h00;
  endproperty
  a_synth_zero: assert property (p_synth_zero)
    else $error("divider values leak while unused");
  property p_flag_clear;
    $fell(timeout_flag) |-> sda_oe || $past(sda_oe);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("alarm cleared without a write");
  c_pulse: cover property ($fell(system_reset_out_n));
  c_reload: cover property (recovery_reload);
  c_soft: cover property (pin_select_bypass && cpu_synth_in_use);
endmodule
bind cg_ctrl_bytes cg_ctrl_bytes_checker cg_ctrl_bytes_checker_inst (
  .core_clk(core_clk), .rstn(rstn), .sda_oe(sda_oe),
  .latched_freq_pins(latched_freq_pins),
  .pin_select_bypass(pin_select_bypass), .prog_cpu_on(prog_cpu_on),
  .soft_freq_select(soft_freq_select),
  .freq_ratio_select(freq_ratio_select),
  .cpu_synth_in_use(cpu_synth_in_use),
  .cpu_synth_multiplier(cpu_synth_multiplier),
  .cpu_synth_divider(cpu_synth_divider), .timeout_flag(timeout_flag),
  .system_reset_out_n(system_reset_out_n),
  .recovery_reload(recovery_reload));

// >>> cg_host_model.sv
// two-wire bus host model for the control bytes
`timescale 1ns/100ps
module cg_host_model (
  input wire core_clk, // system clock
  input wire sda_line, // resolved data line, pulled up
  output reg scl_out, // bus clock, high when idle
  output reg sda_low // pulls data low when set
);
  reg [6:0] dev_addr;
  initial
  begin
    scl_out = 1'b1;
    sda_low = 1'b0;
    dev_addr = 7'h2a;
  end
  // quarter bit of four clocks; lines move just after an edge
  task qt;
    begin
      repeat (4) @(posedge core_clk);
      #1;
    end
  endtask
  // one bit: released means 1, sampled while the clock is high
  task put_bit(input b, output s);
    begin
      sda_low = ~b;
      qt;
      scl_out = 1'b1;
      qt;
      s = sda_line;
      qt;
      scl_out = 1'b0;
      qt;
    end
  endtask
  // eight bits msb first, then the ninth bit
  task xfer(input [7:0] d, input last, output [7:0] q, output ok);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        put_bit(d[i], s);
        q[i] = s;
      end
      put_bit(last, s);
      ok = ~s;
    end
  endtask
  task start_c;
    begin
      sda_low = 1'b0;
      qt;
      scl_out = 1'b1;
      qt;
      sda_low = 1'b1;
      qt;
      scl_out = 1'b0;
      qt;
    end
  endtask
  task stop_c;
    begin
      sda_low = 1'b1;
      qt;
      scl_out = 1'b1;
      qt;
      sda_low = 1'b0;
      qt;
    end
  endtask
  // single byte write; ok only if all three bytes were acknowledged
  task wr(input [7:0] idx, input [7:0] d, output ok);
    reg [7:0] q;
    reg a0, a1, a2;
    begin
      start_c;
      xfer({dev_addr, 1'b0}, 1'b1, q, a0);
      xfer(idx, 1'b1, q, a1);
      xfer(d, 1'b1, q, a2);
      stop_c;
      ok = a0 & a1 & a2;
    end
  endtask
  // single byte read through a repeated start, last byte not acked
  task rd(input [7:0] idx, output [7:0] d);
    reg [7:0] q;
    reg a;
    begin
      start_c;
      xfer({dev_addr, 1'b0}, 1'b1, q, a);
      xfer(idx, 1'b1, q, a);
      start_c;
      xfer({dev_addr, 1'b1}, 1'b1, q, a);
      xfer(8'hff, 1'b1, d, a);
      stop_c;
    end
  endtask
endmodule

// >>> tb_clockgen_ctrl_bytes_seven_to_twelve.sv
// self-checking bench for control bytes 7 to 12
`timescale 1ns/100ps
module tb_clockgen_ctrl_bytes_seven_to_twelve;
  reg core_clk;
  reg rstn;
  reg [4:0] pins;
  reg bypass;
  reg prog_on;
  wire scl, sda, host_low, sda_out, sda_oe, in_use, flag, sys_rst_n, reload;
  wire [14:0] cfg;
  wire [4:0] ratio;
  wire [8:0] mult;
  wire [6:0] div;
  integer num_errors, cmp_count, reloads, i;
  reg ok;
  reg [7:0] d;
  reg [38:0] rows [0:8]; // index, write value, readback, outputs
  reg [47:0] rv;
  assign sda = ~((sda_oe & ~sda_out) | host_low);
  cg_ctrl_bytes #(.WD_SHORT_CYC(26'd200), .WD_LONG_CYC(26'd400))
  cg_ctrl_bytes_inst (.core_clk(core_clk), .rstn(rstn), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .latched_freq_pins(pins), .pin_select_bypass(bypass),
    .prog_cpu_on(prog_on), .cpu_pll_spread_depth(cfg[14]),
    .cpu_pll_spread_shape(cfg[13]), .serial_ref_spread_on(cfg[12]),
    .serial_ref_spread_depth(cfg[11]), .usb_drive_1x(cfg[10]),
    .pci_drive_1x(cfg[9]), .dyn_freq_ceiling(cfg[8:6]),
    .dyn_freq_on(cfg[5]), .soft_freq_select(cfg[4:1]),
    .recovery_use_stored(cfg[0]), .freq_ratio_select(ratio),
    .cpu_synth_in_use(in_use), .cpu_synth_multiplier(mult),
    .cpu_synth_divider(div), .timeout_flag(flag),
    .system_reset_out_n(sys_rst_n), .recovery_reload(reload));
  cg_host_model cg_host_model_inst (.core_clk(core_clk), .sda_line(sda),
    .scl_out(scl), .sda_low(host_low));
  //////////////////////////////////////////////////////////////////////////////
  // clock, and a count of reload pulses
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (reload === 1'b1)
      reloads = reloads + 1;
  task cyc(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  task chk(input [95:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // wait for the timeout flag, at most n cycles
  task wait_flag(input integer n);
    begin
      i = 0;
      while (flag !== 1'b1 && i < n)
      begin
        cyc(1);
        i = i + 1;
      end
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    repeat (60000) @(posedge core_clk);
    num_errors = num_errors + 1;
    report_and_stop;
  end
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    num_errors = 0;
    cmp_count = 0;
    reloads = 0;
    rstn = 1'b0;
    pins = 5'h13;
    bypass = 1'b0;
    prog_on = 1'b0;
    rv = 48'h350600200000;
    rows[0] = {8'h08, 8'hff, 8'hf6, 15'h7e00};
    rows[1] = {8'h08, 8'h09, 8'h00, 15'h0000};
    rows[2] = {8'h08, 8'ha4, 8'ha4, 15'h5400};
    rows[3] = {8'h09, 8'hb5, 8'hb5, 15'h556a};
    rows[4] = {8'h0b, 8'h5a, 8'h5a, 15'h556a};
    rows[5] = {8'h0c, 8'hc3, 8'hc3, 15'h556a};
    rows[6] = {8'h07, 8'hff, 8'h35, 15'h556a};
    rows[7] = {8'h0a, 8'h80, 8'h80, 15'h556b};
    rows[8] = {8'h10, 8'hff, 8'h00, 15'h556b};
    cyc(10);
    rstn = 1'b1;
    chk("reset outs", cfg, 15'h0600);
    for (i = 0; i < 6; i = i + 1)
    begin
      cg_host_model_inst.rd(8'h07 + i[7:0], d);
      chk("reset byte", d, rv[47 - 8 * i -: 8]);
    end
    for (i = 0; i < 9; i = i + 1)
    begin
      cg_host_model_inst.wr(rows[i][38:31], rows[i][30:23], ok);
      cyc(3);
      cg_host_model_inst.rd(rows[i][38:31], d);
      chk("readback", d, rows[i][22:15]);
      chk("outputs", cfg, rows[i][14:0]);
      chk("ack", ok, 1'b1);
    end
    cg_host_model_inst.dev_addr = 7'h2b;
    cg_host_model_inst.wr(8'h09, 8'h00, ok);
    cg_host_model_inst.dev_addr = 7'h2a;
    chk("foreign ack", ok, 1'b0);
    chk("foreign wr", cfg, 15'h556b);
    prog_on = 1'b1;
    bypass = 1'b1;
    cyc(3);
    chk("multiplier", mult, 9'h15a);
    chk("divider", div, 7'h43);
    chk("in use", in_use, 1'b1);
    chk("ratio soft", ratio, 5'h05);
    prog_on = 1'b0;
    bypass = 1'b0;
    cyc(3);
    chk("mult off", mult, 9'h000);
    chk("ratio pins", ratio, 5'h13);
    // long unit, seven units, reset and reload
    cg_host_model_inst.wr(8'h0a, 8'h2f, ok);
    cyc(2740);
    chk("early flag", flag, 1'b0);
    wait_flag(60);
    chk("flag", flag, 1'b1);
    cyc(3);
    chk("sys reset", sys_rst_n, 1'b0);
    chk("reload", reloads, 16'h0001);
    cg_host_model_inst.rd(8'h0a, d);
    chk("alarm", d & 8'hfe, 8'h3e);
    cg_host_model_inst.wr(8'h0a, 8'h20, ok);
    cyc(3);
    chk("alarm clear", flag, 1'b0);
    // short unit, one unit, reset only
    cg_host_model_inst.wr(8'h0a, 8'h43, ok);
    cyc(150);
    chk("short early", flag, 1'b0);
    wait_flag(60);
    chk("short flag", flag, 1'b1);
    cyc(80);
    chk("no reload", reloads, 16'h0001);
    // a started watchdog that is disabled never times out
    cg_host_model_inst.wr(8'h0a, 8'h20, ok);
    cg_host_model_inst.wr(8'h0a, 8'h2f, ok);
    cg_host_model_inst.wr(8'h0a, 8'h2e, ok);
    cyc(3000);
    chk("stopped", flag, 1'b0);
    // test mode: one unit of one clock, reset only; reset cuts the pulse
    cg_host_model_inst.wr(8'h0a, 8'h61, ok);
    cyc(3);
    chk("test mode", flag, 1'b1);
    chk("test rst", sys_rst_n, 1'b0);
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    chk("rerun rst", sys_rst_n, 1'b1);
    chk("rerun flag", flag, 1'b0);
    cg_host_model_inst.rd(8'h08, d);
    chk("rerun reset", d, 8'h06);
    chk("rerun outs", cfg, 15'h0600);
    report_and_stop;
  end
endmodule
